//--- hw/aws_map.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the design and by the package users, no logic here
`ifndef AWS_MAP_SVH
`define AWS_MAP_SVH

`define AWS_OFF_MODE0      32'h0000_0000
`define AWS_OFF_MODE1      32'h0000_0004
`define AWS_OFF_MODE2      32'h0000_0008
`define AWS_OFF_CHSEL      32'h0000_000C
`define AWS_OFF_LIMITS     32'h0000_0010
`define AWS_OFF_RESULT     32'h0000_0014
`define AWS_OFF_STATUS     32'h0000_0018

`define AWS_M0_POWER_BIT   0
`define AWS_M0_ACTIVE_BIT  7
`define AWS_M1_TRIGSEL_LSB 0
`define AWS_M2_WAKE_BIT    2
`define AWS_M2_RCHK_BIT    3
`define AWS_CH_SCAN_BIT    7
`define AWS_LIM_UPPER_LSB  16

`define AWS_RST_MODE1      8'h00
`define AWS_RST_UPPER      10'h3FF
`define AWS_RST_LOWER      10'h000

// power stabilisation wait in ns, then cycles at 50 ns, rounded up
`define AWS_STAB_NS        1000
`define AWS_CLK_NS         50
`define AWS_STAB_CYC       ((`AWS_STAB_NS + `AWS_CLK_NS - 1) / `AWS_CLK_NS)
`define AWS_SCAN_CHANNELS  4

`endif

//--- hw/aws_pkg.sv
// types shared by the snooze conversion sequencer
// assumes: aws_map.svh holds all the numbers
package aws_pkg;

  typedef enum logic [2:0] {
    AWS_IDLE,
    AWS_STAB,
    AWS_CONV,
    AWS_JUDGE,
    AWS_AWAKE
  } aws_state_t;

  // request to the analog core and its answer
  typedef struct packed {
    logic       start;
    logic [4:0] channel;
  } aws_conv_req_t;

  typedef struct packed {
    logic       done;
    logic [9:0] code;
  } aws_conv_rsp_t;

endpackage : aws_pkg

//--- hw/aws_sequencer.sv
// snooze wake sequencer for the converter, ahb-lite slave registers
// assumes: one clock from the high-speed oscillator, converter core
// answers each start with one done pulse, triggers are async pins
//
// Overview of operation
// - no result store when no interrupt
// - trigger in stop starts conversion unaided
// - trigger: request clock, wait, convert
// - trigger from event link or timer
// - interrupt only for result that passes the range check (inside limits, or outside with check select set)
// - select mode interrupt returns to normal
// - scan interrupt on any channel wakes
// - result failing the selected range check suppresses interrupt
// - select mode no interrupt drops clock
// - scan drops clock after fourth channel
// - stay armed for later triggers
// - results are ten-bit codes
// - active bit clears at conversion end
// - scan converts four channels in order
// - trigger mid-scan restarts from first
`timescale 1ns/1ps
`include "aws_map.svh"

module aws_sequencer #(
  parameter int STAB_CYC = `AWS_STAB_CYC
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  hsel_i,
  input  wire logic [31:0]           haddr_i,
  input  wire logic [1:0]            htrans_i,
  input  wire logic                  hwrite_i,
  input  wire logic [2:0]            hsize_i,
  input  wire logic [31:0]           hwdata_i,
  input  wire logic                  hready_i,
  output logic      [31:0]           hrdata_o,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  input  wire logic                  event_link_trig_i,
  input  wire logic                  interval_timer_irq_i,
  input  wire aws_pkg::aws_conv_rsp_t conv_rsp_i,
  output aws_pkg::aws_conv_req_t     conv_req_o,
  output logic                       clock_request_o,
  output logic                       conversion_done_irq_o,
  output logic                       snooze_exit_o
);

  // ----------------------------------------------------------------
  // trigger synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] elc_sync_q, itv_sync_q;
  logic       elc_last_q, itv_last_q;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      elc_sync_q <= 2'h0;
      itv_sync_q <= 2'h0;
      elc_last_q <= 1'b0;
      itv_last_q <= 1'b0;
    end else begin
      elc_sync_q <= {elc_sync_q[0], event_link_trig_i};
      itv_sync_q <= {itv_sync_q[0], interval_timer_irq_i};
      elc_last_q <= elc_sync_q[1];
      itv_last_q <= itv_sync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic       converter_power_on_q, converter_power_on_d;
  logic [7:0] converter_mode_reg_one_q, converter_mode_reg_one_d;
  logic       wakeup_conversion_enable_q, wakeup_conversion_enable_d;
  logic       range_check_select_q, range_check_select_d;
  logic [7:0] channel_select_reg_q, channel_select_reg_d;
  logic [9:0] result_upper_limit_q, result_upper_limit_d;
  logic [9:0] result_lower_limit_q, result_lower_limit_d;
  logic [9:0] conversion_result_word_q, conversion_result_word_d;
  logic       wr_pend_q, wr_pend_d;
  logic [4:0] wr_addr_q, wr_addr_d;
  logic [31:0] hrdata_q, hrdata_d;

  logic       conversion_active;
  aws_pkg::aws_state_t state_q, state_d;
  logic [1:0] slot_q, slot_d;

  wire logic [4:0] acc_addr = haddr_i[4:0];
  wire logic       bus_go   = hsel_i && hready_i && htrans_i[1];

  // trigger: interval timer when low selector bit clear, else event link
  wire logic trig_sel  = converter_mode_reg_one_q[`AWS_M1_TRIGSEL_LSB];
  wire logic trig_edge = trig_sel ? (elc_sync_q[1] && !elc_last_q)
                                  : (itv_sync_q[1] && !itv_last_q);
  wire logic armed = wakeup_conversion_enable_q
                  && converter_power_on_q;
  wire logic trig_ok = trig_edge && armed;
  wire logic scan_mode = channel_select_reg_q[`AWS_CH_SCAN_BIT];

  // range judge, check select picks inside or outside the limits
  wire logic [9:0] code = conv_rsp_i.code;
  wire logic in_lim = (code <= result_upper_limit_q)
                   && (code >= result_lower_limit_q);
  wire logic hit = range_check_select_q ? !in_lim : in_lim;

  always_comb begin
    converter_power_on_d       = converter_power_on_q;
    converter_mode_reg_one_d   = converter_mode_reg_one_q;
    wakeup_conversion_enable_d = wakeup_conversion_enable_q;
    range_check_select_d       = range_check_select_q;
    channel_select_reg_d       = channel_select_reg_q;
    result_upper_limit_d       = result_upper_limit_q;
    result_lower_limit_d       = result_lower_limit_q;
    wr_pend_d                  = bus_go && hwrite_i;
    wr_addr_d                  = acc_addr;
    hrdata_d                   = 32'h0000_0000;
    if (bus_go && !hwrite_i) begin
      unique case ({27'h000_0000, acc_addr})
        `AWS_OFF_MODE0: hrdata_d = {24'h00_0000, conversion_active,
                                    6'h00, converter_power_on_q};
        `AWS_OFF_MODE1: hrdata_d = {24'h00_0000, converter_mode_reg_one_q};
        `AWS_OFF_MODE2: hrdata_d = {28'h000_0000, range_check_select_q,
                                    wakeup_conversion_enable_q, 2'h0};
        `AWS_OFF_CHSEL: hrdata_d = {24'h00_0000, channel_select_reg_q};
        `AWS_OFF_LIMITS: hrdata_d = {6'h00, result_upper_limit_q,
                                     6'h00, result_lower_limit_q};
        `AWS_OFF_RESULT: hrdata_d = {22'h00_0000, conversion_result_word_q};
        `AWS_OFF_STATUS: hrdata_d = {29'h0000_0000, state_q};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_pend_q) begin
      unique case ({27'h000_0000, wr_addr_q})
        `AWS_OFF_MODE0: converter_power_on_d = hwdata_i[`AWS_M0_POWER_BIT];
        `AWS_OFF_MODE1: converter_mode_reg_one_d = hwdata_i[7:0];
        `AWS_OFF_MODE2: begin
          wakeup_conversion_enable_d = hwdata_i[`AWS_M2_WAKE_BIT];
          range_check_select_d       = hwdata_i[`AWS_M2_RCHK_BIT];
        end
        `AWS_OFF_CHSEL: channel_select_reg_d = hwdata_i[7:0];
        `AWS_OFF_LIMITS: begin
          result_upper_limit_d = hwdata_i[`AWS_LIM_UPPER_LSB +: 10];
          result_lower_limit_d = hwdata_i[9:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // snooze sequencer
  // ----------------------------------------------------------------
  logic [15:0] wait_q, wait_d;
  logic        hit_seen_q, hit_seen_d;
  logic        start_q, start_d;
  logic        irq_q, irq_d;
  logic        exit_q, exit_d;
  logic [4:0]  channel_q, channel_d;
  localparam logic [15:0] StabLast = 16'(STAB_CYC - 1);

  assign conversion_active = (state_q == aws_pkg::AWS_CONV);

  always_comb begin
    state_d    = state_q;
    slot_d     = slot_q;
    wait_d     = wait_q;
    hit_seen_d = hit_seen_q;
    start_d    = 1'b0;
    irq_d      = 1'b0;
    exit_d     = exit_q;
    conversion_result_word_d = conversion_result_word_q;
    unique case (state_q)
      aws_pkg::AWS_IDLE: begin
        exit_d = 1'b0;
        if (trig_ok) begin
          state_d    = aws_pkg::AWS_STAB;
          wait_d     = 16'h0000;
          slot_d     = 2'h0;
          hit_seen_d = 1'b0;
        end
      end
      aws_pkg::AWS_STAB: begin
        wait_d = wait_q + 16'h0001;
        if (wait_q == StabLast) begin
          state_d = aws_pkg::AWS_CONV;
          start_d = 1'b1;
        end
      end
      aws_pkg::AWS_CONV: begin
        if (trig_ok && scan_mode) begin
          slot_d  = 2'h0;
          start_d = 1'b1;
        end else if (conv_rsp_i.done) begin
          if (hit) begin
            conversion_result_word_d = code;
            irq_d      = 1'b1;
            hit_seen_d = 1'b1;
          end
          if (scan_mode && slot_q != 2'(`AWS_SCAN_CHANNELS - 1)) begin
            slot_d  = slot_q + 2'h1;
            start_d = 1'b1;
          end else begin
            state_d = aws_pkg::AWS_JUDGE;
          end
        end
      end
      aws_pkg::AWS_JUDGE: begin
        if (hit_seen_q) begin
          state_d = aws_pkg::AWS_AWAKE;
          exit_d  = 1'b1;
        end else begin
          state_d = aws_pkg::AWS_IDLE;
        end
      end
      aws_pkg::AWS_AWAKE: begin
        // normal mode until software drops the wake enable
        if (!wakeup_conversion_enable_q) begin
          state_d = aws_pkg::AWS_IDLE;
          exit_d  = 1'b0;
        end
      end
    endcase
    // registered so the channel never glitches beside the start pulse
    channel_d = channel_select_reg_d[4:0] + {3'h0, slot_d};
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      converter_power_on_q       <= 1'b0;
      converter_mode_reg_one_q   <= `AWS_RST_MODE1;
      wakeup_conversion_enable_q <= 1'b0;
      range_check_select_q       <= 1'b0;
      channel_select_reg_q       <= 8'h00;
      result_upper_limit_q       <= `AWS_RST_UPPER;
      result_lower_limit_q       <= `AWS_RST_LOWER;
      conversion_result_word_q   <= 10'h000;
      wr_pend_q                  <= 1'b0;
      wr_addr_q                  <= 5'h00;
      hrdata_q                   <= 32'h0000_0000;
      state_q                    <= aws_pkg::AWS_IDLE;
      slot_q                     <= 2'h0;
      wait_q                     <= 16'h0000;
      hit_seen_q                 <= 1'b0;
      start_q                    <= 1'b0;
      irq_q                      <= 1'b0;
      exit_q                     <= 1'b0;
      clock_request_o            <= 1'b0;
      channel_q                  <= 5'h00;
    end else begin
      converter_power_on_q       <= converter_power_on_d;
      converter_mode_reg_one_q   <= converter_mode_reg_one_d;
      wakeup_conversion_enable_q <= wakeup_conversion_enable_d;
      range_check_select_q       <= range_check_select_d;
      channel_select_reg_q       <= channel_select_reg_d;
      result_upper_limit_q       <= result_upper_limit_d;
      result_lower_limit_q       <= result_lower_limit_d;
      conversion_result_word_q   <= conversion_result_word_d;
      wr_pend_q                  <= wr_pend_d;
      wr_addr_q                  <= wr_addr_d;
      hrdata_q                   <= hrdata_d;
      state_q                    <= state_d;
      slot_q                     <= slot_d;
      wait_q                     <= wait_d;
      hit_seen_q                 <= hit_seen_d;
      start_q                    <= start_d;
      irq_q                      <= irq_d;
      exit_q                     <= exit_d;
      channel_q                  <= channel_d;
      clock_request_o <= (state_d != aws_pkg::AWS_IDLE)
                      && (state_d != aws_pkg::AWS_AWAKE);
    end
  end

  // channel: low five bits pick the channel, scan adds the slot
  assign conv_req_o.start   = start_q;
  assign conv_req_o.channel = channel_q;
  assign conversion_done_irq_o = irq_q;
  assign snooze_exit_o         = exit_q;
  assign hrdata_o              = hrdata_q;
  assign hreadyout_o           = 1'b1;
  assign hresp_o               = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_trig_needs_arm: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_q == aws_pkg::AWS_IDLE && state_d == aws_pkg::AWS_STAB)
      |-> armed) else $error("trigger taken while not armed");
  a_clk_req_hold: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_q == aws_pkg::AWS_STAB) |=> clock_request_o)
    else $error("clock request dropped in sequence");
  a_no_irq_no_store: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !irq_q |-> $stable(conversion_result_word_q))
    else $error("result stored without interrupt");
  a_irq_in_range: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (conversion_active && conv_rsp_i.done && !hit) |=> !irq_q)
    else $error("interrupt for out of range");
  a_exit_after_hit: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_q == aws_pkg::AWS_JUDGE && hit_seen_q) |=> snooze_exit_o)
    else $error("no exit after interrupt");
  a_drop_no_hit: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_q == aws_pkg::AWS_JUDGE && !hit_seen_q) |=> !clock_request_o)
    else $error("clock kept without interrupt");
  a_stab_wait: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_q == aws_pkg::AWS_IDLE && state_d == aws_pkg::AWS_STAB)
      |=> !start_q [*1] ##0 (state_q == aws_pkg::AWS_STAB))
    else $error("conversion before wait");
  a_scan_restart: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (conversion_active && trig_ok && scan_mode)
      |=> slot_q == 2'h0 && start_q)
    else $error("scan not restarted");

endmodule : aws_sequencer

//--- sim/aws_conv_model.sv
// stand-in for the analog core: one done pulse per start after LAT cycles
// assumes: start is a one-cycle pulse with the channel beside it
`timescale 1ns/1ps

module aws_conv_model #(
  parameter int LAT = 5
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  input  wire aws_pkg::aws_conv_req_t conv_req_i,
  input  wire logic [3:0][9:0]        codes_i,
  output aws_pkg::aws_conv_rsp_t      conv_rsp_o
);
  int         cnt;
  logic [1:0] slot;
  logic [9:0] last;

  always @(posedge sys_clk_i) begin
    conv_rsp_o.done <= 1'b0;
    // idle code lines show junk so a stale code is never taken as valid
    conv_rsp_o.code <= ~last;
    if (reset_i) begin
      cnt  <= 0;
      last <= 10'h000;
    end else if (conv_req_i.start) begin
      cnt  <= LAT;
      slot <= conv_req_i.channel[1:0];
    end else if (cnt == 1) begin
      conv_rsp_o.done <= 1'b1;
      conv_rsp_o.code <= codes_i[slot];
      last            <= codes_i[slot];
      cnt             <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : aws_conv_model

//--- sim/tb_top.sv
// self-checking bench for the snooze wake sequencer
// assumes: single slave on the bus, converter core modelled by aws_conv_model
`timescale 1ns/1ps
`include "aws_map.svh"

module tb_top;
  logic                   sys_clk_i = 1'b0;
  logic                   reset_i   = 1'b1;
  logic [1:0]             htrans    = 2'b00;
  logic [31:0]            haddr     = 32'h0000_0000;
  logic                   hwrite    = 1'b0;
  logic [2:0]             hsize     = 3'b010;
  logic [31:0]            hwdata    = 32'h0000_0000;
  logic                   ev        = 1'b0;
  logic                   itt       = 1'b0;
  logic [3:0][9:0]        codes     = '0;
  logic [31:0]            hrdata;
  logic                   hready;
  logic                   hresp;
  aws_pkg::aws_conv_req_t req;
  aws_pkg::aws_conv_rsp_t rsp;
  logic                   creq;
  logic                   irq;
  logic                   sexit;
  int                     miscompares = 0;
  int                     checks_done = 0;
  int                     cyc         = 0;
  int                     irqs        = 0;
  logic [4:0]             chq[$];
  logic [31:0]            rd;

  aws_sequencer #(.STAB_CYC(3)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .event_link_trig_i(ev), .interval_timer_irq_i(itt),
    .conv_rsp_i(rsp), .conv_req_o(req), .clock_request_o(creq),
    .conversion_done_irq_o(irq), .snooze_exit_o(sexit));

  aws_conv_model model (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .conv_req_i(req),
    .codes_i(codes), .conv_rsp_o(rsp));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge sys_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check("register read", rd, exp);
  endtask : rd_chk

  // hold long enough to pass the two-flop synchroniser
  task automatic pulse(input logic link);
    if (link) ev <= 1'b1;
    else itt <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    ev  <= 1'b0;
    itt <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : pulse

  function automatic logic pick(input int k);
    case (k)
      0:       pick = creq;
      1:       pick = sexit;
      default: pick = (chq.size() >= 2);
    endcase
  endfunction : pick

  task automatic wait_on(input int k, input logic lvl, input string what);
    int n;
    n = 0;
    while (pick(k) !== lvl && n < 300) begin
      @(posedge sys_clk_i);
      n++;
    end
    check(what, {31'b0, pick(k)}, {31'b0, lvl});
  endtask : wait_on

  always @(posedge sys_clk_i) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (req.start === 1'b1) chq.push_back(req.channel);
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    rd_chk(`AWS_OFF_LIMITS, 32'h03FF_0000);
    rd_chk(32'h0000_001C, 32'h0000_0000);
    check("bus response", {31'b0, hresp}, 32'h0000_0000);
    // ------------------------------------------------------------
    // select mode, result in range
    // ------------------------------------------------------------
    codes[0] <= 10'h150;
    // oscillator clock and external inputs only
    wr(`AWS_OFF_MODE1, 32'h0000_00E1);
    wr(`AWS_OFF_LIMITS, 32'h0200_0100);
    wr(`AWS_OFF_CHSEL, 32'h0000_0004);
    wr(`AWS_OFF_MODE2, 32'h0000_0004);
    wr(`AWS_OFF_MODE0, 32'h0000_0001);
    pulse(1'b1);
    wait_on(0, 1'b1, "clock request");
    wait_on(1, 1'b1, "snooze exit");
    check("irq count", irqs, 32'd1);
    rd_chk(`AWS_OFF_RESULT, 32'h0000_0150);
    rd_chk(`AWS_OFF_MODE0, 32'h0000_0001);
    wr(`AWS_OFF_MODE2, 32'h0000_0000);
    // ------------------------------------------------------------
    // select mode, out of range, timer trigger, rearm
    // ------------------------------------------------------------
    codes[0] <= 10'h050;
    wr(`AWS_OFF_MODE1, 32'h0000_00E2);
    wr(`AWS_OFF_MODE2, 32'h0000_0004);
    pulse(1'b0);
    wait_on(0, 1'b1, "clock request");
    wait_on(0, 1'b0, "clock release");
    check("irq count", irqs, 32'd1);
    check("snooze exit", {31'b0, sexit}, 32'h0000_0000);
    rd_chk(`AWS_OFF_RESULT, 32'h0000_0150);
    pulse(1'b0);
    wait_on(0, 1'b1, "rearmed request");
    wait_on(0, 1'b0, "clock release");
    // ------------------------------------------------------------
    // scan, no hit, trigger mid-scan
    // ------------------------------------------------------------
    wr(`AWS_OFF_MODE1, 32'h0000_00E3);
    wr(`AWS_OFF_CHSEL, 32'h0000_0084);
    chq.delete();
    pulse(1'b1);
    wait_on(2, 1'b1, "two starts");
    pulse(1'b1);
    wait_on(0, 1'b0, "scan release");
    check("start count", {31'b0, chq.size() >= 5}, 32'd1);
    for (int i = 0; i < 4; i++) begin
      check("scan channel", chq[chq.size() - 4 + i], 4 + i);
    end
    check("irq count", irqs, 32'd1);
    // ------------------------------------------------------------
    // scan, third slot in range
    // ------------------------------------------------------------
    codes[2] <= 10'h180;
    chq.delete();
    pulse(1'b1);
    wait_on(1, 1'b1, "scan exit");
    check("irq count", irqs, 32'd2);
    check("first channel", chq[0], 32'd4);
    rd_chk(`AWS_OFF_RESULT, 32'h0000_0180);
    wr(`AWS_OFF_MODE2, 32'h0000_0000);
    // ------------------------------------------------------------
    // select mode, outside-limits check hits
    // ------------------------------------------------------------
    wr(`AWS_OFF_CHSEL, 32'h0000_0004);
    wr(`AWS_OFF_MODE2, 32'h0000_000C);
    pulse(1'b1);
    wait_on(1, 1'b1, "outside exit");
    check("irq count", irqs, 32'd3);
    rd_chk(`AWS_OFF_RESULT, 32'h0000_0050);
    wr(`AWS_OFF_MODE2, 32'h0000_0000);
    // ------------------------------------------------------------
    // powered off: trigger ignored
    // ------------------------------------------------------------
    wr(`AWS_OFF_MODE0, 32'h0000_0000);
    wr(`AWS_OFF_MODE2, 32'h0000_0004);
    chq.delete();
    pulse(1'b1);
    repeat (40) @(posedge sys_clk_i);
    check("idle request", {31'b0, creq}, 32'h0000_0000);
    check("idle starts", chq.size(), 32'd0);
    give_verdict();
  end
endmodule : tb_top
